// >>> src/fiqn_pkg.sv
package fiqn_pkg;

    // ****************************************
    // sizes and bus map
    // ****************************************
    localparam int NSRC = 28;
    localparam int NEXT = 6;
    localparam int NEST_W = 8;
    localparam int TRIG_W = 2;
    localparam logic [31:0] ADDR_NEST_CTRL = 32'hFFFF0030;
    localparam logic [31:0] ADDR_TRIG = 32'hFFFF0034;
    localparam logic [31:0] ADDR_ECLR = 32'hFFFF0038;
    localparam logic [31:0] ADDR_NSTAT = 32'hFFFF003C;
    localparam logic [31:0] ADDR_NVEC = 32'hFFFF0040;
    localparam logic [31:0] ADDR_BASE = 32'hFFFF0044;
    localparam logic [31:0] ADDR_EVT_STAT = 32'hFFFF0048;
    localparam logic [31:0] ADDR_EVT_MASK = 32'hFFFF004C;
    localparam logic [31:0] ADDR_FVEC = 32'hFFFF011C;
    localparam logic [31:0] ADDR_FSTAT = 32'hFFFF013C;
    localparam logic [31:0] RST_ZERO = 32'h00000000;

    // ****************************************
    // fields
    // ****************************************
    localparam int CTRL_NORM_NEST = 0;
    localparam int CTRL_FAST_NEST = 1;
    localparam logic [NEST_W-1:0] NEST_NONE = 8'h00;
    localparam logic [3:0] LVL_NONE = 4'h8;
    localparam logic [1:0] TRIG_HIGH = 2'h0;
    localparam logic [1:0] TRIG_LOW = 2'h1;
    localparam logic [1:0] TRIG_RISE = 2'h2;
    localparam logic [1:0] TRIG_FALL = 2'h3;
    // order of the six sources: ext0, ext1, logic0, ext2, ext3, logic1
    localparam int ECLR_BIT [NEXT] = '{13, 16, 17, 18, 19, 20};
    localparam int SRC_IDX [NEXT] = '{14, 15, 16, 17, 18, 19};

    typedef logic [NSRC-1:0][2:0] fiqn_prio_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
    } fiqn_aphase_t;

    typedef struct packed {
        logic found;
        logic [4:0] id;
        logic [2:0] prio;
    } fiqn_pick_t;

endpackage

// >>> src/fiqn_top.sv
// Summary of operation
// - fast vector bits 22:7 return the vector base value.
// - vector bits 6:2 give winning fast source number; bits 31:23 and 1:0 read zero.
// - fast vector read with fast nesting on sets nest bit at winner's priority.
// - a set nest bit blocks interrupts of that priority and lower.
// - each nest status write clears only the highest-priority set bit.
// - four pin and two logic sources, each level or edge triggered.
// - trigger code 11 falling, 10 rising, 01 low level, 00 high level.
// - trigger fields at 1:0, 3:2, 5:4, 7:6, 9:8, 11:10.
// - writing one to an edge-clear bit clears that source's edge latch.
// - trigger, fast vector and fast nest status reset to zero.
// - normal vector read with normal nesting on sets normal nest bit likewise.
// - without nesting, no priorities apply and fast beats normal.
module fiqn_top
    import fiqn_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] ext_pin,
    input wire logic [1:0] logic_irq,
    input wire logic [NSRC-1:0] src_req,
    input wire fiqn_prio_t src_prio,
    input wire logic [NSRC-1:0] fast_source_enable,
    input wire logic [NSRC-1:0] normal_source_enable,
    output logic fiq,
    output logic irq,
    output logic irq_line
);

    // ****************************************
    // state
    // ****************************************
    fiqn_aphase_t ap_d, ap_q;
    logic [31:0] hrdata_d, hrdata_q;
    logic [3:0] sync1_q, sync2_q;
    logic [NEXT-1:0] cur6, prev_q, latch_d, latch_q;
    logic [NEXT-1:0] hit6, evt6, clr6, src6_req;
    logic [2*NEXT-1:0] trig_d, trig_q;
    logic [1:0] ctrl_d, ctrl_q;
    logic [15:0] base_d, base_q;
    logic [NEST_W-1:0] fast_nest_d, fast_nest_q, normal_nest_d, normal_nest_q;
    logic [NEST_W-1:0] fast_drop;
    logic [31:0] fast_vec_d, fast_vec_q, normal_vec_d, normal_vec_q;
    logic [NEXT-1:0] stat_d, stat_q, mask_d, mask_q;
    logic fiq_d, fiq_q, irq_d, irq_q, irq_line_d, irq_line_q;
    logic [NSRC-1:0] req;
    logic [3:0] fthr, nthr;
    fiqn_pick_t fp, np;
    logic fset, nset, fclr, nclr;
    logic [31:0] rdat;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ****************************************
    // helpers
    // ****************************************
    // index of the highest-priority set nest bit, LVL_NONE when clear
    function automatic logic [3:0] top_level(input logic [NEST_W-1:0] st);
        logic [3:0] r;
        r = LVL_NONE;
        for (int b = NEST_W - 1; b >= 0; b--)
        begin
            if (st[b])
                r = 4'(b);
        end
        return r;
    endfunction

    // without nesting the lowest source number wins and levels are ignored
    function automatic fiqn_pick_t pick(
        input logic [NSRC-1:0] pend,
        input fiqn_prio_t pr,
        input logic nest,
        input logic [3:0] thr
    );
        fiqn_pick_t r;
        r = '0;
        for (int s = 0; s < NSRC; s++)
        begin
            if (pend[s] && (!nest || {1'b0, pr[s]} < thr) &&
                (!r.found || (nest && pr[s] < r.prio)))
            begin
                r.found = 1'b1;
                r.id = 5'(s);
                r.prio = pr[s];
            end
        end
        return r;
    endfunction

    // one write drops only the highest-priority bit; a set in the same cycle wins
    function automatic logic [NEST_W-1:0] nest_next(
        input logic [NEST_W-1:0] q,
        input logic clr,
        input logic set,
        input logic [2:0] p
    );
        logic [NEST_W-1:0] v;
        v = q;
        if (clr)
            v = q & (q - 8'h01);
        if (set)
            v[p] = 1'b1;
        return v;
    endfunction

    // ****************************************
    // pin and logic sources
    // ****************************************
    assign cur6 = {logic_irq[1], sync2_q[3], sync2_q[2], logic_irq[0], sync2_q[1], sync2_q[0]};

    generate
        for (genvar i = 0; i < NEXT; i++)
        begin : g_src
            logic [1:0] sel;
            logic lvl, lvl_prev;
            assign sel = trig_q[TRIG_W*i +: TRIG_W];
            assign lvl = cur6[i] ^ sel[0];
            assign lvl_prev = prev_q[i] ^ sel[0];
            assign hit6[i] = (sel == TRIG_RISE) ? (cur6[i] & ~prev_q[i]) :
                             (sel == TRIG_FALL) ? (~cur6[i] & prev_q[i]) : 1'b0;
            assign clr6[i] = ap_q.wr && ap_q.addr == ADDR_ECLR && hwdata[ECLR_BIT[i]];
            // a new edge in the clearing cycle is kept
            assign latch_d[i] = hit6[i] | (latch_q[i] & ~clr6[i]);
            assign src6_req[i] = sel[1] ? latch_q[i] : lvl;
            assign evt6[i] = sel[1] ? hit6[i] : (lvl & ~lvl_prev);

            chk_edge_clear: assert property ((clr6[i] && !hit6[i]) |=> !latch_q[i])
                else $error("edge latch survived its clear");
            chk_level_req: assert property ((sel == TRIG_LOW && !cur6[i] && !ctrl_q[CTRL_FAST_NEST] &&
                fast_source_enable[SRC_IDX[i]]) |=> fiq_q)
                else $error("low level request did not raise fiq");
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        ap_d.wr = hsel && htrans[1] && hready && hwrite;
        ap_d.rd = hsel && htrans[1] && hready && !hwrite;
        ap_d.addr = haddr;

        req = src_req;
        for (int i = 0; i < NEXT; i++)
        begin
            req[SRC_IDX[i]] = src_req[SRC_IDX[i]] | src6_req[i];
        end

        fthr = top_level(fast_nest_q);
        nthr = top_level(normal_nest_q);
        fp = pick(req & fast_source_enable, src_prio, ctrl_q[CTRL_FAST_NEST], fthr);
        np = pick(req & normal_source_enable, src_prio, ctrl_q[CTRL_NORM_NEST], nthr);
        fiq_d = fp.found;
        irq_d = np.found && !fp.found;

        fast_vec_d = {9'h000, base_q, fp.id, 2'h0};
        normal_vec_d = {9'h000, base_q, np.id, 2'h0};

        fset = ap_d.rd && ap_d.addr == ADDR_FVEC && ctrl_q[CTRL_FAST_NEST] && fp.found;
        nset = ap_d.rd && ap_d.addr == ADDR_NVEC && ctrl_q[CTRL_NORM_NEST] && np.found;
        fclr = ap_q.wr && ap_q.addr == ADDR_FSTAT;
        nclr = ap_q.wr && ap_q.addr == ADDR_NSTAT;
        fast_nest_d = nest_next(fast_nest_q, fclr, fset, fp.prio);
        normal_nest_d = nest_next(normal_nest_q, nclr, nset, np.prio);

        trig_d = (ap_q.wr && ap_q.addr == ADDR_TRIG) ? hwdata[2*NEXT-1:0] : trig_q;
        ctrl_d = (ap_q.wr && ap_q.addr == ADDR_NEST_CTRL) ? hwdata[1:0] : ctrl_q;
        base_d = (ap_q.wr && ap_q.addr == ADDR_BASE) ? hwdata[15:0] : base_q;
        mask_d = (ap_q.wr && ap_q.addr == ADDR_EVT_MASK) ? hwdata[NEXT-1:0] : mask_q;
        stat_d = stat_q;
        if (ap_q.wr && ap_q.addr == ADDR_EVT_STAT)
            stat_d = stat_q & ~hwdata[NEXT-1:0];
        stat_d = stat_d | evt6;
        irq_line_d = |(stat_q & mask_q);

        // read data comes from next values so a write just before is seen
        case (ap_d.addr)
            ADDR_NEST_CTRL: rdat = {30'h00000000, ctrl_d};
            ADDR_TRIG: rdat = {20'h00000, trig_d};
            ADDR_ECLR: rdat = RST_ZERO;
            ADDR_NSTAT: rdat = {24'h000000, normal_nest_d};
            ADDR_NVEC: rdat = normal_vec_d;
            ADDR_BASE: rdat = {16'h0000, base_d};
            ADDR_EVT_STAT: rdat = {26'h0000000, stat_d};
            ADDR_EVT_MASK: rdat = {26'h0000000, mask_d};
            ADDR_FVEC: rdat = fast_vec_d;
            ADDR_FSTAT: rdat = {24'h000000, fast_nest_d};
            default: rdat = RST_ZERO;
        endcase
        hrdata_d = ap_d.rd ? rdat : hrdata_q;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_q <= '0;
            hrdata_q <= RST_ZERO;
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            latch_q <= '0;
            trig_q <= '0;
            ctrl_q <= '0;
            base_q <= '0;
            fast_nest_q <= NEST_NONE;
            normal_nest_q <= NEST_NONE;
            fast_vec_q <= RST_ZERO;
            normal_vec_q <= RST_ZERO;
            stat_q <= '0;
            mask_q <= '0;
            fiq_q <= 1'b0;
            irq_q <= 1'b0;
            irq_line_q <= 1'b0;
        end
        else
        begin
            ap_q <= ap_d;
            hrdata_q <= hrdata_d;
            sync1_q <= ext_pin;
            sync2_q <= sync1_q;
            prev_q <= cur6;
            latch_q <= latch_d;
            trig_q <= trig_d;
            ctrl_q <= ctrl_d;
            base_q <= base_d;
            fast_nest_q <= fast_nest_d;
            normal_nest_q <= normal_nest_d;
            fast_vec_q <= fast_vec_d;
            normal_vec_q <= normal_vec_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            fiq_q <= fiq_d;
            irq_q <= irq_d;
            irq_line_q <= irq_line_d;
        end
    end

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign fiq = fiq_q;
    assign irq = irq_q;
    assign irq_line = irq_line_q;

    // ****************************************
    // checks
    // ****************************************
    assign fast_drop = fast_nest_q & (fast_nest_q - 8'h01);

    sequence s_fvec_read;
        ap_d.rd && ap_d.addr == ADDR_FVEC && ctrl_q[CTRL_FAST_NEST] && fp.found;
    endsequence

    sequence s_nvec_read;
        ap_d.rd && ap_d.addr == ADDR_NVEC && ctrl_q[CTRL_NORM_NEST] && np.found;
    endsequence

    chk_vec_zero: assert property (fast_vec_q[31:23] == 9'h000 && fast_vec_q[1:0] == 2'h0)
        else $error("fast vector reserved bits not zero");
    chk_vec_base: assert property (fast_vec_q[22:7] == $past(base_q))
        else $error("fast vector base field wrong");
    chk_nest_set: assert property (s_fvec_read |=> fast_nest_q[$past(fp.prio)])
        else $error("fast vector read did not set nest bit");
    chk_nest_clear: assert property ((fclr && !fset) |=> fast_nest_q == $past(fast_drop))
        else $error("nest write cleared wrong bits");
    chk_fiq_blocked: assert property ((ctrl_q[CTRL_FAST_NEST] && fast_nest_q[0]) |=> !fiq_q)
        else $error("fiq raised while level zero is active");
    chk_fast_first: assert property (fiq_q |-> !irq_q)
        else $error("irq raised together with fiq");
    chk_clear_reads: assert property ((ap_d.rd && ap_d.addr == ADDR_ECLR) |=> hrdata_q == RST_ZERO)
        else $error("edge clear register read non-zero");
    chk_irq_line: assert property ((|(stat_q & mask_q)) |=> irq_line_q)
        else $error("unmasked event did not raise irq_line");
    chk_nvec_zero: assert property (normal_vec_q[31:23] == 9'h000 && normal_vec_q[1:0] == 2'h0)
        else $error("normal vector reserved bits not zero");
    chk_nnest_set: assert property (s_nvec_read |=> normal_nest_q[$past(np.prio)])
        else $error("normal vector read did not set nest bit");
    chk_nnest_clear: assert property ((nclr && !nset) |=> normal_nest_q == $past(normal_nest_q & (normal_nest_q - 8'h01)))
        else $error("normal nest write cleared wrong bits");

endmodule // fiqn_top

// >>> verif/fiqn_core_model.sv
module fiqn_core_model
    import fiqn_pkg::*;
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rd_data;
    event rd_ev;

    // ****************************************
    // single word transfers, one per call
    // ****************************************
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'h0;
        // a released data bus toggles so a stale value never reads as a match
        hwdata <= wr ? d : ~hwdata;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        if (!wr)
        begin
            rd_data = hrdata;
            -> rd_ev;
        end
    endtask
endmodule // fiqn_core_model

// >>> verif/fiqn_top_test.sv
module fiqn_top_test
    import fiqn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string n; logic [31:0] v;} fiqn_note_t;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fiq, irq, irq_line;
    logic [31:0] haddr, hwdata, hrdata, r, base;
    logic [1:0] htrans, logic_irq;
    logic [2:0] hsize;
    logic [3:0] ext_pin;
    logic [NSRC-1:0] src_req, fse, nse;
    fiqn_prio_t src_prio;
    fiqn_note_t exp_q[$];
    int mismatches, compares;
    event ln_ev;

    fiqn_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .ext_pin, .logic_irq, .src_req, .src_prio, .fast_source_enable(fse),
        .normal_source_enable(nse), .fiq, .irq, .irq_line);
    fiqn_core_model u_core (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata);

    // ****************************************
    // scoreboard
    // ****************************************
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic take(input logic [31:0] s);
        fiqn_note_t t;
        t = exp_q.pop_front();
        check(t.n, s, t.v);
    endtask
    always @(u_core.rd_ev) take(u_core.rd_data);
    always @(ln_ev) take({29'h0, fiq, irq, irq_line});

    task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back('{n, e});
        u_core.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        u_core.xfer(1'b1, a, d);
    endtask
    // order is fiq, irq, irq_line; probed after the edge has settled
    task automatic lines(input string n, input logic [2:0] e);
        @(posedge hclk);
        #1;
        exp_q.push_back('{n, {29'h0, e}});
        -> ln_ev;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial
    begin
        #300us;
        mismatches++;
        print_verdict();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        hresetn = 1'b0;
        ext_pin = 4'h0;
        logic_irq = 2'h0;
        src_req = '0;
        src_prio = '0;
        fse = '0;
        nse = '0;
        r = $urandom(73962);
        cyc(2);
        hresetn <= 1'b1;
        rd("trig rst", ADDR_TRIG, RST_ZERO);
        rd("fvec rst", ADDR_FVEC, RST_ZERO);
        rd("fstat rst", ADDR_FSTAT, RST_ZERO);
        rd("unmapped", 32'hFFFF0100, RST_ZERO);
        r = $urandom() & 32'h00000FFF;
        wr(ADDR_TRIG, r);
        rd("trig rw", ADDR_TRIG, r);
        wr(ADDR_ECLR, 32'h001F2000);
        rd("eclr", ADDR_ECLR, RST_ZERO);
        wr(ADDR_TRIG, {30'h0, TRIG_RISE});
        wr(ADDR_ECLR, 32'h001F2000);
        wr(ADDR_EVT_STAT, 32'h0000003F);
        fse[14] <= 1'b1;
        ext_pin[0] <= 1'b1;
        cyc(6);
        lines("ext0 rise", 3'b100);
        ext_pin[0] <= 1'b0;
        cyc(6);
        lines("edge held", 3'b100);
        rd("evt stat", ADDR_EVT_STAT, 32'h00000001);
        wr(ADDR_EVT_MASK, 32'h00000001);
        cyc(1);
        lines("unmasked", 3'b101);
        wr(ADDR_ECLR, 32'h00002000);
        wr(ADDR_EVT_STAT, 32'h00000001);
        cyc(2);
        lines("cleared", 3'b000);
        fse <= '0;
        nse[16] <= 1'b1;
        wr(ADDR_TRIG, {26'h0, TRIG_LOW, 4'h0});
        cyc(3);
        lines("low lvl", 3'b010);
        fse[16] <= 1'b1;
        cyc(3);
        lines("low fast", 3'b100);
        fse <= '0;
        logic_irq[0] <= 1'b1;
        cyc(3);
        lines("lvl gone", 3'b000);
        wr(ADDR_TRIG, {26'h0, TRIG_FALL, 4'h0});
        logic_irq[0] <= 1'b0;
        cyc(3);
        lines("fall", 3'b010);
        wr(ADDR_ECLR, 32'h00020000);
        cyc(2);
        lines("fall clr", 3'b000);
        wr(ADDR_TRIG, {22'h0, TRIG_FALL, 8'h0});
        ext_pin[3] <= 1'b1;
        fse[18] <= 1'b1;
        cyc(4);
        lines("ext3 idle", 3'b000);
        ext_pin[3] <= 1'b0;
        cyc(6);
        lines("ext3 fall", 3'b100);
        wr(ADDR_ECLR, 32'h00080000);
        cyc(2);
        lines("ext3 clr", 3'b000);
        fse <= '0;
        wr(ADDR_TRIG, {26'h0, TRIG_HIGH, 4'h0});
        logic_irq[0] <= 1'b1;
        cyc(3);
        lines("high lvl", 3'b010);
        logic_irq[0] <= 1'b0;
        nse <= 28'h0000080;
        fse <= 28'h0000100;
        src_req <= 28'h0000180;
        cyc(3);
        lines("fast wins", 3'b100);
        src_req <= '0;
        nse <= '0;
        base = $urandom() & 32'h0000FFFF;
        wr(ADDR_BASE, base);
        wr(ADDR_NEST_CTRL, 32'h00000002);
        src_prio[4] <= 3'd3;
        src_prio[5] <= 3'd0;
        fse <= 28'h0000030;
        src_req[4] <= 1'b1;
        cyc(3);
        rd("fvec 4", ADDR_FVEC, {9'h0, base[15:0], 5'd4, 2'h0});
        rd("fstat set", ADDR_FSTAT, 32'h00000008);
        lines("blocked", 3'b000);
        src_req[5] <= 1'b1;
        cyc(3);
        lines("higher", 3'b100);
        rd("fvec 5", ADDR_FVEC, {9'h0, base[15:0], 5'd5, 2'h0});
        rd("fstat 09", ADDR_FSTAT, 32'h00000009);
        wr(ADDR_FSTAT, 32'h000000FF);
        rd("fstat 08", ADDR_FSTAT, 32'h00000008);
        wr(ADDR_FSTAT, 32'h000000FF);
        rd("fstat 00", ADDR_FSTAT, RST_ZERO);
        src_req <= '0;
        fse <= '0;
        wr(ADDR_NEST_CTRL, 32'h00000001);
        src_prio[6] <= 3'd2;
        nse[6] <= 1'b1;
        src_req[6] <= 1'b1;
        cyc(3);
        rd("nvec 6", ADDR_NVEC, {9'h0, base[15:0], 5'd6, 2'h0});
        rd("nstat set", ADDR_NSTAT, 32'h00000004);
        lines("nblock", 3'b000);
        wr(ADDR_NSTAT, 32'h000000FF);
        rd("nstat clr", ADDR_NSTAT, RST_ZERO);
        print_verdict();
    end
endmodule // fiqn_top_test
